// *** shared/ipv_pkg.sv ***
// shared constants and types for interrupt priority resolution and vectoring
// assumes one 10 MHz clock and a core that fetches vector entries on request
package ipv_pkg;
    localparam int NSRC = 16;
    localparam int NFLD = 8;
    localparam int FLD_W = 3;
    localparam int IDX_W = 4;
    localparam int LVL_W = 4;
    localparam int ADDR_W = 32;
    localparam logic [LVL_W-1:0] PRIO_RESET = 4'h0;
    localparam logic [7:0] VEC_NUM_BASE = 8'h40;
    localparam int VEC_SHIFT = 2;

    typedef enum logic [3:0] {
        IPV_OP_OTHER,
        IPV_OP_JMP,
        IPV_OP_JSR,
        IPV_OP_BRA,
        IPV_OP_BSR,
        IPV_OP_RTS,
        IPV_OP_RTE,
        IPV_OP_BF_S,
        IPV_OP_BT_S,
        IPV_OP_BSRF,
        IPV_OP_BRAF
    } ipv_op_t;

    typedef struct packed {
        logic addr_err;
        logic fpu_exc;
        logic bank_ovf;
    } ipv_exc_t;

    typedef struct packed {
        logic [7:0]       vec_num;
        logic [IDX_W-1:0] idx;
        logic [LVL_W-1:0] lvl;
    } ipv_vec_t;

    // sources 0..3 own a field each; 4..15 share fields 4..7 in groups of three
    function automatic logic [FLD_W-1:0] ipv_field_of(input logic [IDX_W-1:0] idx);
        if (idx < 4'h4) begin
            ipv_field_of = idx[FLD_W-1:0];
        end else begin
            ipv_field_of = FLD_W'(3'h4 + FLD_W'((idx - 4'h4) / 4'h3));
        end
    endfunction

    function automatic logic ipv_is_delayed(input ipv_op_t op);
        ipv_is_delayed = (op != IPV_OP_OTHER);
    endfunction

    function automatic logic [ADDR_W-1:0] ipv_vec_addr(input logic [ADDR_W-1:0] base,
                                                       input logic [7:0] vnum);
        ipv_vec_addr = base + (ADDR_W'(vnum) << VEC_SHIFT);
    endfunction
endpackage

// *** src/ipv_resolve.sv ***
// combinational pick of the highest pending level above the core mask
// assumes levels arrive already mapped from the shared priority fields
module ipv_resolve (
    input  wire logic [ipv_pkg::NSRC-1:0]                     req,
    input  wire logic [ipv_pkg::NSRC-1:0][ipv_pkg::LVL_W-1:0] lvl,
    input  wire logic [ipv_pkg::LVL_W-1:0]                    mask,
    output logic                                              hit,
    output logic [ipv_pkg::IDX_W-1:0]                         idx,
    output logic [ipv_pkg::LVL_W-1:0]                         best
);
    import ipv_pkg::*;

    always_comb begin
        hit  = 1'b0;
        idx  = '0;
        best = mask;
        // strict compare keeps the lower index on ties, so the fixed order needs no table
        for (int i = 0; i < NSRC; i++) begin
            if (req[i] && (lvl[i] > best)) begin
                hit  = 1'b1;
                idx  = IDX_W'(i);
                best = lvl[i];
            end
        end
    end
endmodule

// *** src/ipv_ctrl.sv ***
// interrupt priority resolution, vector fetch and delay-slot deferral
// assumes sources hold their request until serviced and the core answers fetches
//
// Summary of operation
// - each source gets own vector and address
// - handler address fetched from computed table entry
// - priority fields programmable from zero to fifteen
// - shared field ordered by fixed source order
// - power-on reset clears every priority to zero
// - equal levels resolved by fixed default order
// - events after delayed branch held, taken later
// - deferral covers every delayed branch instruction
module ipv_ctrl (
    input  wire logic                                 MCLK,
    input  wire logic                                 RST_N,
    input  wire logic [ipv_pkg::NSRC-1:0]             SRC_REQ,
    input  wire logic                                 PRIO_WE,
    input  wire logic [ipv_pkg::FLD_W-1:0]            PRIO_SEL,
    input  wire logic [ipv_pkg::LVL_W-1:0]            PRIO_DATA,
    output logic      [ipv_pkg::LVL_W-1:0]            PRIO_RDATA,
    input  wire logic [ipv_pkg::LVL_W-1:0]            CPU_MASK,
    input  wire logic [ipv_pkg::ADDR_W-1:0]           VEC_TABLE_BASE,
    input  wire logic                                 DEC_VALID,
    input  wire ipv_pkg::ipv_op_t                     DEC_OP,
    input  wire ipv_pkg::ipv_exc_t                    EXC_RAISE,
    output ipv_pkg::ipv_exc_t                         EXC_TAKE,
    output logic                                      FETCH_REQ,
    output logic      [ipv_pkg::ADDR_W-1:0]           FETCH_ADDR,
    input  wire logic                                 FETCH_ACK,
    input  wire logic [ipv_pkg::ADDR_W-1:0]           FETCH_DATA,
    output logic                                      INT_VALID,
    output ipv_pkg::ipv_vec_t                         INT_INFO,
    output logic      [ipv_pkg::ADDR_W-1:0]           INT_HANDLER
);
    import ipv_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_DONE} ipv_state_t;

    logic [LVL_W-1:0]            fld_ff   [NFLD];
    logic [LVL_W-1:0]            nxt_fld  [NFLD];
    logic [NSRC-1:0][LVL_W-1:0]  src_lvl;
    logic                        slot_ff;
    logic                        nxt_slot;
    ipv_exc_t                    pend_ff;
    ipv_exc_t                    nxt_pend;
    ipv_exc_t                    pend_all;
    ipv_exc_t                    take_ff;
    ipv_exc_t                    nxt_take;
    ipv_state_t                  state_ff;
    ipv_state_t                  nxt_state;
    ipv_vec_t                    vec_ff;
    ipv_vec_t                    nxt_vec;
    logic [ADDR_W-1:0]           handler_ff;
    logic [ADDR_W-1:0]           nxt_handler;
    logic [ADDR_W-1:0]           faddr_ff;
    logic [ADDR_W-1:0]           nxt_faddr;
    logic [LVL_W-1:0]            rdata_ff;
    logic                        accept;
    logic                        res_hit;
    logic [IDX_W-1:0]            res_idx;
    logic [LVL_W-1:0]            res_lvl;

    // priority fields; a write lands one cycle later
    always_comb begin
        for (int f = 0; f < NFLD; f++) begin
            nxt_fld[f] = fld_ff[f];
        end
        if (PRIO_WE) begin
            nxt_fld[PRIO_SEL] = PRIO_DATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            for (int f = 0; f < NFLD; f++) begin
                fld_ff[f] <= PRIO_RESET;
            end
            rdata_ff <= PRIO_RESET;
        end else begin
            for (int f = 0; f < NFLD; f++) begin
                fld_ff[f] <= nxt_fld[f];
            end
            rdata_ff <= fld_ff[PRIO_SEL];
        end
    end

    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            src_lvl[i] = fld_ff[ipv_field_of(IDX_W'(i))];
        end
    end

    ipv_resolve u_resolve (
        .req  (SRC_REQ),
        .lvl  (src_lvl),
        .mask (CPU_MASK),
        .hit  (res_hit),
        .idx  (res_idx),
        .best (res_lvl)
    );

    // the slot after a delayed branch cannot take anything
    assign accept   = DEC_VALID && !slot_ff;
    assign pend_all = pend_ff | EXC_RAISE;

    always_comb begin
        nxt_slot = slot_ff;
        if (DEC_VALID) begin
            nxt_slot = ipv_is_delayed(DEC_OP);
        end
        // a raise in the take cycle is taken with it, so nothing is lost
        nxt_pend = accept ? '0 : pend_all;
        nxt_take = accept ? pend_all : '0;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            slot_ff <= 1'b0;
            pend_ff <= '0;
            take_ff <= '0;
        end else begin
            slot_ff <= nxt_slot;
            pend_ff <= nxt_pend;
            take_ff <= nxt_take;
        end
    end

    // interrupts yield to pending exceptions and wait for the next accepting decode
    always_comb begin
        nxt_state   = state_ff;
        nxt_vec     = vec_ff;
        nxt_handler = handler_ff;
        nxt_faddr   = faddr_ff;
        case (state_ff)
            S_IDLE: begin
                if (accept && (pend_all == '0) && res_hit) begin
                    nxt_vec.idx     = res_idx;
                    nxt_vec.lvl     = res_lvl;
                    nxt_vec.vec_num = VEC_NUM_BASE + 8'(res_idx);
                    nxt_faddr = ipv_vec_addr(VEC_TABLE_BASE, nxt_vec.vec_num);
                    nxt_state = S_FETCH;
                end
            end
            S_FETCH: begin
                if (FETCH_ACK) begin
                    nxt_handler = FETCH_DATA;
                    nxt_state   = S_DONE;
                end
            end
            S_DONE: begin
                nxt_state = S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_ff   <= S_IDLE;
            vec_ff     <= '0;
            handler_ff <= '0;
            faddr_ff   <= '0;
        end else begin
            state_ff   <= nxt_state;
            vec_ff     <= nxt_vec;
            handler_ff <= nxt_handler;
            faddr_ff   <= nxt_faddr;
        end
    end

    assign FETCH_REQ   = (state_ff == S_FETCH);
    assign FETCH_ADDR  = faddr_ff;
    assign INT_VALID   = (state_ff == S_DONE);
    assign INT_INFO    = vec_ff;
    assign INT_HANDLER = handler_ff;
    assign EXC_TAKE    = take_ff;
    assign PRIO_RDATA  = rdata_ff;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_vec_address: assert property (FETCH_REQ |->
        FETCH_ADDR == VEC_TABLE_BASE + {22'h0, INT_INFO.vec_num, 2'h0})
        else $error("vector table address does not match vector number");
    a_fetch_start: assert property ((state_ff == S_IDLE) && accept && (pend_all == '0)
        && res_hit |=> FETCH_REQ && INT_INFO.idx == $past(res_idx))
        else $error("accepted interrupt did not start a vector fetch");
    a_handler_load: assert property (FETCH_REQ && FETCH_ACK |=>
        INT_VALID && INT_HANDLER == $past(FETCH_DATA))
        else $error("handler address not taken from the fetched entry");
    a_prio_write: assert property (PRIO_WE ##1 !PRIO_WE && PRIO_SEL == $past(PRIO_SEL)
        |=> PRIO_RDATA == $past(PRIO_DATA, 2))
        else $error("priority field did not store the written level");
    // a higher level elsewhere may still win, so only the order inside the shared pair is checked
    a_shared_order: assert property (SRC_REQ[4] && SRC_REQ[5]
        && src_lvl[4] > CPU_MASK |-> res_hit && res_idx != 4'h5)
        else $error("shared field sources not in fixed order");
    a_tie_order: assert property (res_hit && SRC_REQ[0] && src_lvl[0] == res_lvl
        |-> res_idx == 4'h0)
        else $error("equal level tie not resolved by default order");
    // a fetch already under way may go on through a slot; only a new start is wrong
    a_slot_defer: assert property (DEC_VALID && slot_ff |=>
        EXC_TAKE == '0 && !$rose(FETCH_REQ))
        else $error("event taken in a delayed branch slot");
    a_slot_taken: assert property (accept && (pend_all != '0) |=>
        EXC_TAKE == $past(pend_all))
        else $error("held exception not taken at accepting decode");
    a_exc_first: assert property (accept && (pend_all != '0) |=>
        !$rose(FETCH_REQ))
        else $error("interrupt started ahead of a pending exception");
    a_branch_set: assert property (DEC_VALID && DEC_OP != IPV_OP_OTHER |=> slot_ff)
        else $error("delayed branch did not open a slot");
    a_mask_level: assert property (FETCH_REQ |-> INT_INFO.lvl != 4'h0)
        else $error("level zero source requested the core");
    a_reset_zero: assert property ($rose(RST_N) |-> fld_ff[0] == 4'h0
        && fld_ff[NFLD-1] == 4'h0)
        else $error("priority not zero after reset");

    c_int_taken: cover property (FETCH_REQ && FETCH_ACK);
    c_slot_hold: cover property (slot_ff && DEC_VALID && (pend_all != '0));
    c_tie: cover property (res_hit && SRC_REQ[0] && SRC_REQ[1] && src_lvl[0] == src_lvl[1]);
endmodule

// *** verif/ipv_core_model.sv ***
// core side model: answers vector fetches after a chosen number of idle cycles
// assumes the controller holds fetch_req and fetch_addr until the ack edge
module ipv_core_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  slow,
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_ack,
    output logic [31:0]      fetch_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wt;
    // data toggles outside the ack cycle so a stale sample never matches
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fetch_ack <= 1'b0;
            wt <= 2'h0;
            fetch_data <= 32'h0;
        end else if (fetch_ack) begin
            fetch_ack <= 1'b0;
            fetch_data <= ~fetch_data;
        end else if (fetch_req && wt >= slow) begin
            fetch_ack <= 1'b1;
            wt <= 2'h0;
            fetch_data <= fetch_addr ^ 32'h5A5A_0000;
        end else begin
            wt <= fetch_req ? wt + 2'h1 : 2'h0;
            fetch_data <= ~fetch_data;
        end
    end
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the priority and vectoring controller
// assumes ipv_pkg, ipv_resolve, ipv_ctrl and ipv_core_model are compiled first
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ipv_pkg::*;
    logic              MCLK = 1'b0, RST_N = 1'b0, PRIO_WE = 1'b0, DEC_VALID = 1'b0;
    logic [NSRC-1:0]   SRC_REQ = '0;
    logic [FLD_W-1:0]  PRIO_SEL = '0;
    logic [LVL_W-1:0]  PRIO_DATA = '0, CPU_MASK = '0, PRIO_RDATA;
    logic [ADDR_W-1:0] VEC_TABLE_BASE = '0, FETCH_ADDR, FETCH_DATA, INT_HANDLER;
    ipv_op_t           DEC_OP = IPV_OP_OTHER;
    ipv_exc_t          EXC_RAISE = '0, EXC_TAKE, exp_e;
    logic              FETCH_REQ, FETCH_ACK, INT_VALID;
    ipv_vec_t          INT_INFO;
    logic [1:0]        slow = 2'h0;
    logic [47:0]       exp_i;
    logic [3:0]        lv[8];
    logic [47:0]       int_q[$];
    ipv_exc_t          exc_q[$];
    int                num_errors = 0, checked = 0, cyc = 0;

    ipv_ctrl u_ipv_ctrl (.MCLK(MCLK), .RST_N(RST_N), .SRC_REQ(SRC_REQ), .PRIO_WE(PRIO_WE),
        .PRIO_SEL(PRIO_SEL), .PRIO_DATA(PRIO_DATA), .PRIO_RDATA(PRIO_RDATA),
        .CPU_MASK(CPU_MASK), .VEC_TABLE_BASE(VEC_TABLE_BASE), .DEC_VALID(DEC_VALID),
        .DEC_OP(DEC_OP), .EXC_RAISE(EXC_RAISE), .EXC_TAKE(EXC_TAKE), .FETCH_REQ(FETCH_REQ),
        .FETCH_ADDR(FETCH_ADDR), .FETCH_ACK(FETCH_ACK), .FETCH_DATA(FETCH_DATA),
        .INT_VALID(INT_VALID), .INT_INFO(INT_INFO), .INT_HANDLER(INT_HANDLER));
    ipv_core_model u_ipv_core_model (.mclk(MCLK), .rst_n(RST_N), .slow(slow),
        .fetch_req(FETCH_REQ), .fetch_addr(FETCH_ADDR), .fetch_ack(FETCH_ACK),
        .fetch_data(FETCH_DATA));

    initial forever #50 MCLK = ~MCLK;

    task automatic wrap_up;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            wrap_up;
        end
    end

    // an empty queue yields x, so any unexpected result counts as a mismatch
    always @(negedge MCLK) begin
        if (INT_VALID === 1'b1) begin
            exp_i = (int_q.size() > 0) ? int_q.pop_front() : 'x;
            `CHK({INT_INFO, INT_HANDLER}, exp_i)
        end
        if (EXC_TAKE !== 3'h0) begin
            exp_e = (exc_q.size() > 0) ? exc_q.pop_front() : 'x;
            `CHK(EXC_TAKE, exp_e)
        end
    end

    task automatic dec(input ipv_op_t op, input ipv_exc_t e);
        @(posedge MCLK);
        DEC_VALID <= 1'b1;
        DEC_OP <= op;
        EXC_RAISE <= e;
    endtask

    task automatic idle;
        @(posedge MCLK);
        DEC_VALID <= 1'b0;
        EXC_RAISE <= '0;
    endtask

    task automatic prio_wr(input int f, input logic [3:0] d);
        @(posedge MCLK);
        PRIO_WE <= 1'b1;
        PRIO_SEL <= 3'(f);
        PRIO_DATA <= d;
        @(posedge MCLK);
        PRIO_WE <= 1'b0;
    endtask

    task automatic prio_rd(input int f, input logic [3:0] d);
        @(posedge MCLK);
        PRIO_SEL <= 3'(f);
        @(posedge MCLK);
        @(negedge MCLK);
        `CHK(PRIO_RDATA, d)
    endtask

    initial begin
        int bi;
        logic [3:0] bl, mask;
        logic [15:0] req;
        logic [31:0] base;
        ipv_exc_t e;
        void'($urandom(32'h711c5f15));
        repeat (2) @(posedge MCLK);
        RST_N <= 1'b1;
        for (int f = 0; f < 8; f++) prio_rd(f, 4'h0);
        // every source requests at level zero: nothing may reach the core
        @(posedge MCLK) SRC_REQ <= '1;
        dec(IPV_OP_OTHER, '0);
        idle;
        repeat (8) @(negedge MCLK);
        `CHK(FETCH_REQ, 1'b0)
        @(posedge MCLK) SRC_REQ <= '0;
        for (int f = 0; f < 8; f++) begin
            prio_wr(f, 4'hF);
            prio_rd(f, 4'hF);
        end
        for (int k = 1; k <= 10; k++) begin
            e = ipv_exc_t'(3'($urandom_range(7, 1)));
            dec(ipv_op_t'(k), '0);
            dec(IPV_OP_OTHER, e);
            exc_q.push_back(e);
            dec(IPV_OP_OTHER, '0);
            @(negedge MCLK);
            `CHK(EXC_TAKE, 3'h0)
            idle;
        end
        for (int t = 0; t < 30; t++) begin
            for (int f = 0; f < 8; f++) begin
                lv[f] = 4'($urandom_range(3) * 5);
                prio_wr(f, lv[f]);
            end
            req = 16'($urandom);
            mask = 4'($urandom_range(12));
            base = $urandom & 32'hFFFF_FC00;
            bi = -1;
            bl = mask;
            for (int i = 0; i < 16; i++) begin
                if (req[i] && lv[i < 4 ? i : 4 + (i - 4) / 3] > bl) begin
                    bi = i;
                    bl = lv[i < 4 ? i : 4 + (i - 4) / 3];
                end
            end
            if (bi >= 0) begin
                int_q.push_back({8'(bi) + 8'h40, 4'(bi), bl,
                                 (base + 32'((bi + 64) * 4)) ^ 32'h5A5A_0000});
            end
            // requests appear in the delay slot and must wait for the next decode
            dec(IPV_OP_BRA, '0);
            dec(IPV_OP_OTHER, '0);
            SRC_REQ <= req;
            CPU_MASK <= mask;
            VEC_TABLE_BASE <= base;
            slow <= 2'($urandom);
            dec(IPV_OP_OTHER, '0);
            @(negedge MCLK);
            `CHK(FETCH_REQ, 1'b0)
            idle;
            for (int w = 0; w < 12 && INT_VALID !== 1'b1; w++) @(negedge MCLK);
            @(posedge MCLK) SRC_REQ <= '0;
        end
        repeat (4) @(posedge MCLK);
        `CHK(int_q.size() + exc_q.size(), 0)
        wrap_up;
    end
endmodule
